// ==== core/dcc_consts.svh ====
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define DCC_CLK_MHZ 50
`define DCC_CYCLE_US 250
`define DCC_CYCLE_CYC (`DCC_CYCLE_US * `DCC_CLK_MHZ)
`define DCC_MDT_US 150
`define DCC_MDT_CYC (`DCC_MDT_US * `DCC_CLK_MHZ)
`define DCC_AT_US 20
`define DCC_AT_CYC (`DCC_AT_US * `DCC_CLK_MHZ)
`define DCC_ERR_LIMIT 2'd2

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define DCC_CW_ON 15
`define DCC_CW_EN 14
`define DCC_CW_MODE_LO 8
`define DCC_CW_RT_LO 6
`define DCC_CW_MHS 5

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define DCC_SW_RDY_OP 15
`define DCC_SW_RDY_PWR 14
`define DCC_SW_C1 13
`define DCC_SW_C2 12
`define DCC_SW_C3 11
`define DCC_SW_HALT 10
`define DCC_SW_MODE_LO 8
`define DCC_SW_RT_LO 6
`define DCC_SW_AHS 5
`define DCC_SW_MODE_ERR 4

// ----------------------------------------
// Supported modes and item list
// ----------------------------------------
`define DCC_MODES_SUPP 4'h7
`define DCC_ITEM_POS 16'h0010
`define DCC_ITEM_VEL 16'h0020
`define DCC_ITEM_TRQ 16'h0030
`define DCC_ITEM_NONE 16'hffff

// ----------------------------------------
// Controller registers
// ----------------------------------------
`define DCC_REG_CTRL 8'h00
`define DCC_REG_CMD_POS 8'h04
`define DCC_REG_CMD_VEL 8'h08
`define DCC_REG_CMD_TRQ 8'h0c
`define DCC_REG_SVC_TX 8'h10
`define DCC_REG_SVC_RX 8'h14
`define DCC_REG_STAT 8'h18
`define DCC_REG_FB_POS 8'h1c
`define DCC_REG_FB_VEL 8'h20
`define DCC_REG_FB_TRQ 8'h24
`define DCC_REG_IRQ_ST 8'h28
`define DCC_REG_IRQ_MASK 8'h2c
`define DCC_CR_PHASE 0
`define DCC_CR_ON 1
`define DCC_CR_EN 2
`define DCC_CR_MODE_LO 4
`define DCC_CR_RT_LO 6
`define DCC_CR_INJ 8
`define DCC_CR_RST 16'h0000
`define DCC_EV_AT 0
`define DCC_EV_SVC 1
`define DCC_EV_MISS 2
`define DCC_EV_HALT 3

`endif

// ==== core/dcc_drive.sv ====
// Function
// - Cycles repeat at strictly equal intervals
// - Apply commands, capture feedback at sync
// - On error continue, reuse previous value
// - Repeated errors trigger predetermined fault reaction
// - Service transfers acknowledged or repeated
// - One control, one status word per cycle
// - Words split drive part, transmit part
// - Two real-time bits each way each cycle
// - Decode mode, drive on, enable commands
// - Status: three fault classes, ready flags
// - Cyclic configuration frozen after initialization
// - Declare supported subset of operating modes
// - Main mode plus secondary modes, switchable
// - Readable lists of supported items
// - Position mode takes velocity, torque feedforward
// - Halt after two consecutive bad transfers
// - Keep position command after halt; velocity, torque zeroed
`timescale 1ns/1ps
`include "dcc_consts.svh"
module dcc_drive (
    input wire logic clk,
    input wire logic reset_n,
    dcc_link_if.drive link,
    input wire logic [31:0] fb_pos,
    input wire logic [31:0] fb_vel,
    input wire logic [31:0] fb_trq,
    input wire logic [2:0] fault_class,
    input wire logic [1:0] rt_in,
    input wire dcc_pkg::dcc_mode_t cfg_main_mode,
    input wire dcc_pkg::dcc_mode_t cfg_sec_mode1,
    input wire dcc_pkg::dcc_mode_t cfg_sec_mode2,
    input wire dcc_pkg::dcc_mode_t cfg_sec_mode3,
    output logic [31:0] cmd_pos,
    output logic [31:0] cmd_vel,
    output logic [31:0] cmd_trq,
    output dcc_pkg::dcc_mode_t act_mode,
    output logic power_on,
    output logic torque_enable,
    output logic axis_halt,
    output logic [1:0] rt_out
);
    import dcc_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [15:0] pend_cw_q;
    logic [31:0] pend_pos_q;
    logic [31:0] pend_vel_q;
    logic [31:0] pend_trq_q;
    logic got_q;
    logic [1:0] err_cnt_q;
    logic [1:0] err_cnt_d;
    logic halt_q;
    dcc_mode_t mode_tab_q [0:3];
    dcc_mode_t mode_q;
    logic mode_err_q;
    logic on_q;
    logic en_q;
    logic [1:0] rt_q;
    logic [1:0] rt_in_q;
    logic [31:0] cpos_q;
    logic [31:0] cvel_q;
    logic [31:0] ctrq_q;
    logic [31:0] fbc_pos_q;
    logic [31:0] fbc_vel_q;
    logic [31:0] fbc_trq_q;
    logic [15:0] svc_rep_q;
    logic ahs_q;
    dcc_at_st_t at_st_q;
    logic [9:0] at_cnt_q;
    logic at_v_q;
    logic [15:0] sw_q;
    logic [15:0] sw_d;

    // ----------------------------------------
    // Supported item list
    // ----------------------------------------
    function automatic logic [15:0] list_entry(input logic [7:0] idx);
        case (idx)
            8'h00: list_entry = {12'h000, `DCC_MODES_SUPP};
            8'h01: list_entry = `DCC_ITEM_POS;
            8'h02: list_entry = `DCC_ITEM_VEL;
            8'h03: list_entry = `DCC_ITEM_TRQ;
            default: list_entry = `DCC_ITEM_NONE;
        endcase
    endfunction

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire mdt_good = link.mdt_valid && link.mdt_ok;
    wire sync = link.sync;
    wire fresh = got_q;
    wire counting = link.op_phase;
    wire [1:0] mode_sel = pend_cw_q[`DCC_CW_MODE_LO +: 2];
    wire dcc_mode_t req_mode = mode_tab_q[mode_sel];
    wire req_ok = dcc_mode_ok(`DCC_MODES_SUPP, req_mode);
    wire new_req = link.ctrl_word[`DCC_CW_MHS] != ahs_q;
    wire svc_take = mdt_good && new_req;
    wire halt_set = sync && counting && !fresh
        && err_cnt_d == `DCC_ERR_LIMIT;
    wire halt_clr = sync && fresh && !pend_cw_q[`DCC_CW_ON];

    always_comb begin
        if (!counting || fresh) begin
            err_cnt_d = 2'd0;
        end else if (err_cnt_q == `DCC_ERR_LIMIT) begin
            err_cnt_d = err_cnt_q;
        end else begin
            err_cnt_d = err_cnt_q + 2'd1;
        end
    end

    // ----------------------------------------
    // Command reception
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_cw_q <= 16'h0000;
            pend_pos_q <= 32'h00000000;
            pend_vel_q <= 32'h00000000;
            pend_trq_q <= 32'h00000000;
            got_q <= 1'b0;
        end else begin
            // Bad telegram leaves the last valid values in place
            if (mdt_good) begin
                pend_cw_q <= link.ctrl_word;
                pend_pos_q <= link.cmd_pos;
                pend_vel_q <= link.cmd_vel;
                pend_trq_q <= link.cmd_trq;
            end
            got_q <= mdt_good || (got_q && !sync);
        end
    end

    // ----------------------------------------
    // Configuration, frozen in operation
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_tab_q[0] <= DCC_TORQUE;
            mode_tab_q[1] <= DCC_TORQUE;
            mode_tab_q[2] <= DCC_TORQUE;
            mode_tab_q[3] <= DCC_TORQUE;
        end else if (!link.op_phase) begin
            mode_tab_q[0] <= cfg_main_mode;
            mode_tab_q[1] <= cfg_sec_mode1;
            mode_tab_q[2] <= cfg_sec_mode2;
            mode_tab_q[3] <= cfg_sec_mode3;
        end
    end

    // ----------------------------------------
    // Apply at the cycle boundary
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            err_cnt_q <= 2'd0;
            halt_q <= 1'b0;
            mode_q <= DCC_TORQUE;
            mode_err_q <= 1'b0;
            on_q <= 1'b0;
            en_q <= 1'b0;
            rt_q <= 2'b00;
            cpos_q <= 32'h00000000;
            cvel_q <= 32'h00000000;
            ctrq_q <= 32'h00000000;
        end else if (sync) begin
            err_cnt_q <= err_cnt_d;
            if (halt_set) begin
                halt_q <= 1'b1;
            end else if (halt_clr) begin
                halt_q <= 1'b0;
            end
            if (fresh) begin
                if (req_ok) begin
                    mode_q <= req_mode;
                end
                mode_err_q <= !req_ok;
                on_q <= pend_cw_q[`DCC_CW_ON];
                en_q <= pend_cw_q[`DCC_CW_EN];
                rt_q <= pend_cw_q[`DCC_CW_RT_LO +: 2];
                cpos_q <= pend_pos_q;
                cvel_q <= pend_vel_q;
                ctrq_q <= pend_trq_q;
            end
            if (halt_set || halt_q) begin
                en_q <= 1'b0;
                cvel_q <= 32'h00000000;
                ctrq_q <= 32'h00000000;
            end
        end
    end

    // ----------------------------------------
    // Service channel
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            svc_rep_q <= 16'h0000;
            ahs_q <= 1'b0;
        end else if (svc_take) begin
            svc_rep_q <= list_entry(link.svc_m[7:0]);
            ahs_q <= link.ctrl_word[`DCC_CW_MHS];
        end
    end

    // ----------------------------------------
    // Feedback capture and answer telegram
    // ----------------------------------------
    always_comb begin
        sw_d = 16'h0000;
        sw_d[`DCC_SW_RDY_OP] = on_q && en_q && !halt_q && !fault_class[0];
        sw_d[`DCC_SW_RDY_PWR] = !halt_q && !fault_class[0];
        sw_d[`DCC_SW_C1] = fault_class[0] || halt_q;
        sw_d[`DCC_SW_C2] = fault_class[1];
        sw_d[`DCC_SW_C3] = fault_class[2];
        sw_d[`DCC_SW_HALT] = halt_q;
        sw_d[`DCC_SW_MODE_LO +: 2] = mode_q;
        sw_d[`DCC_SW_RT_LO +: 2] = rt_in_q;
        sw_d[`DCC_SW_AHS] = ahs_q;
        sw_d[`DCC_SW_MODE_ERR] = mode_err_q;
    end

    wire at_fire = at_st_q == AT_WAIT
        && at_cnt_q == 10'(`DCC_AT_CYC - 1);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fbc_pos_q <= 32'h00000000;
            fbc_vel_q <= 32'h00000000;
            fbc_trq_q <= 32'h00000000;
            rt_in_q <= 2'b00;
        end else if (sync) begin
            fbc_pos_q <= fb_pos;
            fbc_vel_q <= fb_vel;
            fbc_trq_q <= fb_trq;
            rt_in_q <= rt_in;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            at_st_q <= AT_IDLE;
            at_cnt_q <= 10'h000;
            at_v_q <= 1'b0;
            sw_q <= 16'h0000;
        end else begin
            at_v_q <= at_fire;
            if (at_fire) begin
                sw_q <= sw_d;
            end
            case (at_st_q)
                AT_IDLE: begin
                    at_cnt_q <= 10'h000;
                    if (sync) at_st_q <= AT_WAIT;
                end
                AT_WAIT: begin
                    at_cnt_q <= at_cnt_q + 10'h001;
                    if (at_fire) at_st_q <= AT_IDLE;
                end
                default: at_st_q <= AT_IDLE;
            endcase
        end
    end

    assign link.at_valid = at_v_q;
    assign link.status_word = sw_q;
    assign link.svc_a = svc_rep_q;
    assign link.fb_pos = fbc_pos_q;
    assign link.fb_vel = fbc_vel_q;
    assign link.fb_trq = fbc_trq_q;
    assign cmd_pos = cpos_q;
    assign cmd_vel = cvel_q;
    assign cmd_trq = ctrq_q;
    assign act_mode = mode_q;
    assign power_on = on_q;
    assign torque_enable = en_q;
    assign axis_halt = halt_q;
    assign rt_out = rt_q;
endmodule

// ==== core/dcc_link_if.sv ====
`timescale 1ns/1ps
interface dcc_link_if;
    logic sync;
    logic op_phase;
    logic mdt_valid;
    logic mdt_ok;
    logic [15:0] ctrl_word;
    logic [15:0] svc_m;
    logic [31:0] cmd_pos;
    logic [31:0] cmd_vel;
    logic [31:0] cmd_trq;
    logic at_valid;
    logic [15:0] status_word;
    logic [15:0] svc_a;
    logic [31:0] fb_pos;
    logic [31:0] fb_vel;
    logic [31:0] fb_trq;

    modport master (
        output sync, op_phase, mdt_valid, mdt_ok, ctrl_word, svc_m,
        output cmd_pos, cmd_vel, cmd_trq,
        input at_valid, status_word, svc_a, fb_pos, fb_vel, fb_trq
    );
    modport drive (
        input sync, op_phase, mdt_valid, mdt_ok, ctrl_word, svc_m,
        input cmd_pos, cmd_vel, cmd_trq,
        output at_valid, status_word, svc_a, fb_pos, fb_vel, fb_trq
    );
endinterface

// ==== core/dcc_master.sv ====
`timescale 1ns/1ps
`include "dcc_consts.svh"
module dcc_master #(
    parameter int CYCLE_CYC = `DCC_CYCLE_CYC,
    parameter int MDT_CYC = `DCC_MDT_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    dcc_link_if.master link
);
    import dcc_pkg::*;

    logic [15:0] ctrl_q;
    logic [31:0] cpos_q;
    logic [31:0] cvel_q;
    logic [31:0] ctrq_q;
    logic [31:0] mpos_q;
    logic [31:0] mvel_q;
    logic [31:0] mtrq_q;
    logic [15:0] svc_tx_q;
    logic [15:0] svc_rx_q;
    logic mhs_q;
    logic busy_q;
    logic [15:0] stat_q;
    logic [31:0] fpos_q;
    logic [31:0] fvel_q;
    logic [31:0] ftrq_q;
    logic [3:0] irq_st_q;
    logic [3:0] irq_st_d;
    logic [3:0] irq_mask_q;
    logic [3:0] ev;
    logic at_seen_q;
    logic [15:0] cnt_q;
    logic sync_q;
    logic mdt_v_q;
    logic mdt_ok_q;
    logic [15:0] cw_q;
    logic [15:0] cw_d;
    logic [31:0] prdata_q;
    logic [31:0] rdata;
    logic hit;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    wire setup = psel && !penable;
    wire wr = psel && penable && pready_q && pwrite;
    wire wr_ctrl = wr && paddr == `DCC_REG_CTRL;
    wire wr_svc = wr && paddr == `DCC_REG_SVC_TX;
    wire wr_ist = wr && paddr == `DCC_REG_IRQ_ST;

    always_comb begin
        hit = 1'b1;
        if (paddr == `DCC_REG_CTRL) begin
            rdata = {16'h0000, ctrl_q};
        end else if (paddr == `DCC_REG_CMD_POS) begin
            rdata = cpos_q;
        end else if (paddr == `DCC_REG_CMD_VEL) begin
            rdata = cvel_q;
        end else if (paddr == `DCC_REG_CMD_TRQ) begin
            rdata = ctrq_q;
        end else if (paddr == `DCC_REG_SVC_TX) begin
            rdata = {16'h0000, svc_tx_q};
        end else if (paddr == `DCC_REG_SVC_RX) begin
            rdata = {15'h0000, busy_q, svc_rx_q};
        end else if (paddr == `DCC_REG_STAT) begin
            rdata = {16'h0000, stat_q};
        end else if (paddr == `DCC_REG_FB_POS) begin
            rdata = fpos_q;
        end else if (paddr == `DCC_REG_FB_VEL) begin
            rdata = fvel_q;
        end else if (paddr == `DCC_REG_FB_TRQ) begin
            rdata = ftrq_q;
        end else if (paddr == `DCC_REG_IRQ_ST) begin
            rdata = {28'h0000000, irq_st_q};
        end else if (paddr == `DCC_REG_IRQ_MASK) begin
            rdata = {28'h0000000, irq_mask_q};
        end else begin
            rdata = 32'h00000000;
            hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !hit;
            prdata_q <= setup ? rdata : 32'h00000000;
        end
    end

    // ----------------------------------------
    // Equidistant cycle timing
    // ----------------------------------------
    wire cyc_end = cnt_q == 16'(CYCLE_CYC - 1);
    wire mdt_now = cnt_q == 16'(MDT_CYC);

    always_comb begin
        cw_d = 16'h0000;
        cw_d[`DCC_CW_ON] = ctrl_q[`DCC_CR_ON];
        cw_d[`DCC_CW_EN] = ctrl_q[`DCC_CR_EN];
        cw_d[`DCC_CW_MODE_LO +: 2] = ctrl_q[`DCC_CR_MODE_LO +: 2];
        cw_d[`DCC_CW_RT_LO +: 2] = ctrl_q[`DCC_CR_RT_LO +: 2];
        cw_d[`DCC_CW_MHS] = mhs_q;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 16'h0000;
            sync_q <= 1'b0;
            mdt_v_q <= 1'b0;
            mdt_ok_q <= 1'b0;
            cw_q <= 16'h0000;
            mpos_q <= 32'h00000000;
            mvel_q <= 32'h00000000;
            mtrq_q <= 32'h00000000;
        end else begin
            cnt_q <= cyc_end ? 16'h0000 : cnt_q + 16'h0001;
            sync_q <= cyc_end;
            mdt_v_q <= mdt_now;
            if (mdt_now) begin
                cw_q <= cw_d;
                // Commands change on the link only with the record
                mpos_q <= cpos_q;
                mvel_q <= cvel_q;
                mtrq_q <= ctrq_q;
                mdt_ok_q <= !ctrl_q[`DCC_CR_INJ];
            end
        end
    end

    // ----------------------------------------
    // Registers, service channel, feedback
    // ----------------------------------------
    wire at_v = link.at_valid;
    wire ack = busy_q && at_v
        && link.status_word[`DCC_SW_AHS] == mhs_q;
    wire miss = sync_q && ctrl_q[`DCC_CR_PHASE] && !at_seen_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `DCC_CR_RST;
            cpos_q <= 32'h00000000;
            cvel_q <= 32'h00000000;
            ctrq_q <= 32'h00000000;
            svc_tx_q <= 16'h0000;
            svc_rx_q <= 16'h0000;
            mhs_q <= 1'b0;
            busy_q <= 1'b0;
            irq_mask_q <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[15:0];
            end else if (mdt_now) begin
                ctrl_q[`DCC_CR_INJ] <= 1'b0;
            end
            if (wr && paddr == `DCC_REG_CMD_POS) cpos_q <= pwdata;
            if (wr && paddr == `DCC_REG_CMD_VEL) cvel_q <= pwdata;
            if (wr && paddr == `DCC_REG_CMD_TRQ) ctrq_q <= pwdata;
            if (wr && paddr == `DCC_REG_IRQ_MASK) irq_mask_q <= pwdata[3:0];
            // Held handshake repeats the request every cycle until echoed
            if (wr_svc && !busy_q) begin
                svc_tx_q <= pwdata[15:0];
                mhs_q <= !mhs_q;
                busy_q <= 1'b1;
            end else if (ack) begin
                svc_rx_q <= link.svc_a;
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_q <= 16'h0000;
            fpos_q <= 32'h00000000;
            fvel_q <= 32'h00000000;
            ftrq_q <= 32'h00000000;
            at_seen_q <= 1'b0;
        end else begin
            // Missing answer keeps the previous feedback
            if (at_v) begin
                stat_q <= link.status_word;
                fpos_q <= link.fb_pos;
                fvel_q <= link.fb_vel;
                ftrq_q <= link.fb_trq;
            end
            at_seen_q <= at_v || (at_seen_q && !sync_q);
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    always_comb begin
        ev = 4'h0;
        ev[`DCC_EV_AT] = at_v;
        ev[`DCC_EV_SVC] = ack;
        ev[`DCC_EV_MISS] = miss;
        ev[`DCC_EV_HALT] = at_v && link.status_word[`DCC_SW_HALT];
        irq_st_d = (irq_st_q & ~(wr_ist ? pwdata[3:0] : 4'h0)) | ev;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_st_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            irq_st_q <= irq_st_d;
            irq_q <= |(irq_st_q & irq_mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign link.sync = sync_q;
    assign link.op_phase = ctrl_q[`DCC_CR_PHASE];
    assign link.mdt_valid = mdt_v_q;
    assign link.mdt_ok = mdt_ok_q;
    assign link.ctrl_word = cw_q;
    assign link.svc_m = svc_tx_q;
    assign link.cmd_pos = mpos_q;
    assign link.cmd_vel = mvel_q;
    assign link.cmd_trq = mtrq_q;
endmodule

// ==== core/dcc_pkg.sv ====
package dcc_pkg;

    typedef enum logic [1:0] {
        DCC_TORQUE,
        DCC_VELOCITY,
        DCC_POSITION,
        DCC_INTERP
    } dcc_mode_t;

    typedef enum logic {
        AT_IDLE,
        AT_WAIT
    } dcc_at_st_t;

    function automatic logic dcc_mode_ok(input logic [3:0] supp,
                                         input dcc_mode_t m);
        dcc_mode_ok = supp[m];
    endfunction

endpackage

// ==== testbench/dcc_checker.sv ====
`timescale 1ns/1ps
module dcc_checker #(
    parameter int CYCLE_CYC = 1500,
    parameter int MDT_CYC = 1200
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sync,
    input wire logic mdt_valid,
    input wire logic mdt_ok,
    input wire logic [15:0] ctrl_word,
    input wire logic [31:0] cmd_pos,
    input wire logic at_valid,
    input wire logic [15:0] status_word,
    input wire logic [31:0] fb_pos
);
    logic [15:0] cnt_q;
    logic seen_q;
    logic mhs_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // Clocks since last cycle start
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 16'h0000;
            seen_q <= 1'b0;
            mhs_q <= 1'b0;
        end else begin
            cnt_q <= sync ? 16'h0000 : cnt_q + 16'h0001;
            seen_q <= seen_q | sync;
            if (mdt_valid && mdt_ok) mhs_q <= ctrl_word[5];
        end
    end
    sequence s_one(x);
        x ##1 !x;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_sync_period: assert property (
        sync && seen_q |-> cnt_q == CYCLE_CYC - 1)
        else $error("sync spacing wrong");
    chk_sync_pulse: assert property (sync |-> s_one(sync))
        else $error("sync not a single pulse");
    chk_mdt_slot: assert property (
        mdt_valid && seen_q |-> cnt_q == MDT_CYC)
        else $error("command record off its slot");
    chk_at_slot: assert property (at_valid |-> seen_q && cnt_q == 1000)
        else $error("status record off its slot");
    chk_fb_hold: assert property (
        ($changed(status_word) |-> at_valid)
        and ($changed(fb_pos) |-> $past(sync)))
        else $error("feedback changed outside its record");
    chk_cmd_hold: assert property (
        $changed({ctrl_word, cmd_pos}) |-> mdt_valid)
        else $error("command changed outside its record");
    chk_ahs_echo: assert property (
        mdt_valid && seen_q |-> status_word[5] == mhs_q)
        else $error("handshake not echoed");
    chk_halt_class: assert property (
        status_word[10] |-> status_word[13])
        else $error("halt without class 1 error");
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import dcc_pkg::*;
    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, v, fbp = 32'h0;
    logic pready, pslverr, irq, err, pon, ten, halt;
    logic [31:0] dpos, dvel, dtrq;
    logic [31:0] lst[$] = '{32'h7, 32'h10, 32'h20, 32'h30, 32'hffff};
    logic [2:0] fcls = 3'h0;
    logic [1:0] rti = 2'h0, rto;
    dcc_mode_t amode;
    int bad_count = 0, compares = 0, seed = 32'ha1de0bc1;
    dcc_link_if link();
    dcc_master #(.CYCLE_CYC(1500), .MDT_CYC(1200)) dcc_master_i(.clk(clk),
        .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link));
    dcc_drive dcc_drive_i(.clk(clk), .reset_n(reset_n), .link(link),
        .fb_pos(fbp), .fb_vel(~fbp), .fb_trq(fbp + 32'h1),
        .fault_class(fcls), .rt_in(rti), .cfg_main_mode(DCC_TORQUE),
        .cfg_sec_mode1(DCC_VELOCITY), .cfg_sec_mode2(DCC_POSITION),
        .cfg_sec_mode3(DCC_INTERP), .cmd_pos(dpos), .cmd_vel(dvel),
        .cmd_trq(dtrq), .act_mode(amode), .power_on(pon),
        .torque_enable(ten), .axis_halt(halt), .rt_out(rto));
    dcc_checker #(.CYCLE_CYC(1500), .MDT_CYC(1200)) dcc_checker_i(.clk(clk),
        .reset_n(reset_n), .sync(link.sync), .mdt_valid(link.mdt_valid),
        .mdt_ok(link.mdt_ok), .ctrl_word(link.ctrl_word),
        .cmd_pos(link.cmd_pos), .at_valid(link.at_valid),
        .status_word(link.status_word), .fb_pos(link.fb_pos));
    initial forever #10 clk = ~clk;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [63:0] e, g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cyc(input int n);
        repeat (n * 1500) @(posedge clk);
    endtask
    task wrap_up;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        wrap_up;
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1;
        @(posedge clk);
        v = $random(seed);
        fbp <= $random(seed);
        rti <= 2'h2;
        fcls <= 3'h5;
        bus(1, 8'h04, v);
        bus(1, 8'h08, ~v);
        bus(1, 8'h0c, v + 1);
        bus(1, 8'h00, 32'hc7);
        cyc(3);
        chk("cmd_pos", v, dpos);
        chk("cmd_ff", {~v, v + 32'h1}, {dvel, dtrq});
        chk("rt_on_en", 4'hf, {rto, pon, ten});
        bus(0, 8'h1c, 0);
        chk("fb_pos", fbp, rd);
        bus(0, 8'h18, 0);
        chk("status", 8'ha2, rd[13:6]);
        $display("test cyclic done");
        for (int i = 0; i < 4; i++) begin
            bus(1, 8'h00, 32'h7 | (i << 4));
            cyc(3);
            chk("act_mode", (i == 3) ? 2 : i, amode);
            bus(0, 8'h18, 0);
            chk("mode_err", i == 3, rd[4]);
        end
        $display("test modes done");
        foreach (lst[i]) begin
            bus(1, 8'h10, i);
            cyc(3);
            bus(0, 8'h14, 0);
            chk("svc_reply", lst[i], rd[16:0]);
        end
        bus(0, 8'h40, 0);
        chk("unmapped", 33'h100000000, {err, rd});
        $display("test service done");
        bus(1, 8'h00, 32'h107);
        cyc(3);
        chk("one_bad", {v, 2'h1}, {dpos, halt, ten});
        bus(1, 8'h00, 32'h107);
        cyc(1);
        bus(1, 8'h00, 32'h107);
        cyc(3);
        chk("two_bad", {v, 2'h2}, {dpos, halt, ten});
        chk("halt_vel", 0, dvel);
        bus(1, 8'h2c, 32'h8);
        repeat (2) @(posedge clk);
        chk("irq_on", 1, irq);
        bus(1, 8'h2c, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq_masked", 0, irq);
        bus(1, 8'h28, 32'hf);
        bus(0, 8'h28, 0);
        chk("irq_clear", 0, rd[3]);
        bus(1, 8'h00, 32'h5);
        cyc(3);
        chk("unhalt", 0, halt);
        $display("test errors done");
        wrap_up;
    end
endmodule
